// ### logic/rms_pkg.sv
// Shared constants and types for the reset and mode strap block
package rms_pkg;
   localparam int SYNC_STAGES = 2;
   localparam int NUMERICS_DELAY_CLKS = 4;
   localparam int STRAP_COUNT = 7;
   localparam int STRAP_READ = 0;
   localparam int STRAP_UPPER = 1;
   localparam int STRAP_LOWER = 2;
   localparam int STRAP_MID0 = 3;
   localparam int STRAP_MID1 = 4;
   localparam int STRAP_LOCK = 5;
   localparam int STRAP_BUSY = 6;
   localparam logic [2:0] ABORT_CLKS = 3'h2;
   typedef enum logic [3:0] {
      RMS_ST_RUN = 4'h1,
      RMS_ST_DEASSERT = 4'h2,
      RMS_ST_FLOAT = 4'h4,
      RMS_ST_HOLD = 4'h8
   } rms_state_t;
endpackage

// ### logic/rms_reset_strap.sv
// Reset synchroniser, bus abort sequencing and mode strap sampling
`timescale 1ns/1ns
//
// Contract
// [R1] Core stays in full reset whenever external reset input is low; here only via the synchroniser, two clocks late, and not without a clock.
// [R2] External reset passes a clocked synchroniser before internal use.
// [R3] Board holds reset low from power-on onward.
// [R4] Board holds reset until supply and crystal clock are stable.
// [R5] Warm reset stops all activity and returns to defined state.
// [R6] Active bus transfer aborts: controls driven inactive first, then floated.
// [R7] During reset strap pins are inputs with weak pull-ups; here only in hold, so they stay driven for the first reset clock and any abort.
// [R8] Upper and lower chip selects low at reset select isolation test mode.
// [R9] Read strobe strap low at reset selects queue status mode.
// [R10] Busy high at reset, low four clocks later enables numerics mode.
// [R11] Board never pulls bus-lock low during reset.
// [R12] Straps latch at synchronised reset release; pins then return to outputs.
module rms_reset_strap (
   input wire logic i_sys_clk, // System clock, 100 MHz
   input wire logic i_srst, // Synchronous power-on reset, active high
   input wire logic i_external_reset_n, // Board reset pin, active low
   input wire logic [rms_pkg::STRAP_COUNT-1:0] i_strap_pin, // Strap pin levels
   input wire logic i_bus_active, // Core has a bus transfer in progress
   output logic o_core_reset, // Reset to core, active high
   output logic o_ctrl_inactive, // Force bus controls to inactive level
   output logic o_ctrl_float, // Float bus control outputs
   output logic [rms_pkg::STRAP_COUNT-1:0] o_strap_oe, // Strap pin output enables
   output logic [rms_pkg::STRAP_COUNT-1:0] o_strap_pullup, // Weak pull-up enables
   output logic o_isolation_test_mode, // Isolation test mode latched
   output logic o_queue_status_mode, // Queue status mode latched
   output logic o_numerics_mode, // Numerics coprocessor mode latched
   output logic o_lock_strap_fault // Bus-lock was seen low during reset
);
   logic reset_n_sync;
   logic [rms_pkg::STRAP_COUNT-1:0] strap_sync;
   logic reset_req;
   rms_pkg::rms_state_t state;
   rms_pkg::rms_state_t next_state;
   logic [2:0] abort_cnt;
   logic [rms_pkg::NUMERICS_DELAY_CLKS-1:0] busy_hist;
   logic upper_low;
   logic lower_low;
   logic read_low;
   logic lock_low;
   logic busy_seq;
   logic in_hold;
   logic busy_low;
   logic [2:0] next_abort_cnt;
   logic [rms_pkg::SYNC_STAGES-1:0] settle;
   logic [rms_pkg::SYNC_STAGES-1:0] next_settle;
   logic pins_settled;
   logic entering_reset;
   logic [rms_pkg::NUMERICS_DELAY_CLKS-1:0] next_busy_hist;
   logic next_isolation;
   logic next_queue;
   logic next_numerics;
   logic next_lock_fault;

   // A strap counts as asserted when its synchronised level is low
   function automatic logic strap_low(
      input logic [rms_pkg::STRAP_COUNT-1:0] levels,
      input int idx
   );
      return ~levels[idx];
   endfunction

   rms_sync #(.RESET_VALUE(1'b0)) u_reset_sync ( // [R2]
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_async(i_external_reset_n),
      .o_sync(reset_n_sync)
   );

   // Strap pins are from the board, so each is synchronised too
   genvar g;
   generate
      for (g = 0; g < rms_pkg::STRAP_COUNT; g++) begin : g_strap
         rms_sync #(.RESET_VALUE(1'b1)) u_strap_sync (
            .i_sys_clk(i_sys_clk),
            .i_srst(i_srst),
            .i_async(i_strap_pin[g]),
            .o_sync(strap_sync[g])
         );
      end
   endgenerate

   // Either power-on reset or the synchronised pin holds the core; the pin is
   // only seen through the synchroniser, so it has no effect without a clock
   assign reset_req = i_srst | ~reset_n_sync; // [R1]
   assign in_hold = (state == rms_pkg::RMS_ST_HOLD);

   // Abort sequence: inactive drive for a short time, then float, then hold
   always_comb begin
      next_state = state;
      unique case (state)
         rms_pkg::RMS_ST_RUN: begin
            if (reset_req) begin
               next_state = i_bus_active ? rms_pkg::RMS_ST_DEASSERT
                                         : rms_pkg::RMS_ST_HOLD; // [R6]
            end
         end
         rms_pkg::RMS_ST_DEASSERT: begin
            if (abort_cnt == rms_pkg::ABORT_CLKS - 3'h1) begin
               next_state = rms_pkg::RMS_ST_FLOAT; // [R6]
            end
         end
         rms_pkg::RMS_ST_FLOAT: begin
            next_state = rms_pkg::RMS_ST_HOLD;
         end
         rms_pkg::RMS_ST_HOLD: begin
            if (!reset_req) begin
               next_state = rms_pkg::RMS_ST_RUN; // [R12]
            end
         end
      endcase
   end

   // Counts clocks spent driving controls inactive; rests at zero elsewhere
   assign next_abort_cnt = (state == rms_pkg::RMS_ST_DEASSERT) ? abort_cnt + 3'h1 : 3'h0;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         state <= rms_pkg::RMS_ST_HOLD;
      end else begin
         state <= next_state; // [R5]
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         abort_cnt <= 3'h0;
      end else begin
         abort_cnt <= next_abort_cnt;
      end
   end

   // Core stays reset through the whole abort and hold sequence
   assign o_core_reset = (state != rms_pkg::RMS_ST_RUN) | reset_req; // [R1] [R5]
   assign o_ctrl_inactive = (state == rms_pkg::RMS_ST_DEASSERT); // [R6]
   assign o_ctrl_float = (state == rms_pkg::RMS_ST_FLOAT) | in_hold; // [R6]
   assign o_strap_oe = in_hold ? '0 : '1; // [R7] [R12]
   assign o_strap_pullup = in_hold ? '1 : '0; // [R7]

   assign upper_low = strap_low(strap_sync, rms_pkg::STRAP_UPPER);
   assign lower_low = strap_low(strap_sync, rms_pkg::STRAP_LOWER);
   assign read_low = strap_low(strap_sync, rms_pkg::STRAP_READ);
   assign lock_low = strap_low(strap_sync, rms_pkg::STRAP_LOCK);
   assign busy_low = strap_low(strap_sync, rms_pkg::STRAP_BUSY);

   // For the first clocks of hold the synchronisers still show the pins' own
   // output drive; only samples taken after that count as strap levels
   assign next_settle = in_hold ? {settle[rms_pkg::SYNC_STAGES-2:0], 1'b1} : '0;
   assign pins_settled = in_hold & settle[rms_pkg::SYNC_STAGES-1];
   assign entering_reset = (state == rms_pkg::RMS_ST_RUN) & reset_req;

   // History is cleared outside settled hold, so a level seen while the pin
   // was still an output can never pair with a later strapped low
   assign next_busy_hist = pins_settled
                           ? {busy_hist[rms_pkg::NUMERICS_DELAY_CLKS-2:0], ~busy_low}
                           : '0;
   // Oldest history bit is the busy level four clocks ago
   assign busy_seq = pins_settled & busy_hist[rms_pkg::NUMERICS_DELAY_CLKS-1]
                     & busy_low; // [R10]

   // Modes track the straps while held and freeze at release
   assign next_isolation = pins_settled ? (upper_low & lower_low)
                                        : o_isolation_test_mode; // [R8] [R12]
   assign next_queue = pins_settled ? read_low : o_queue_status_mode; // [R9] [R12]
   // Numerics and lock fault are only set inside hold; a new reset clears them
   assign next_numerics = ~entering_reset & (o_numerics_mode | busy_seq); // [R10]
   // Lock low is illegal; flag only, behaviour is not guaranteed
   assign next_lock_fault = ~entering_reset
                            & (o_lock_strap_fault | (pins_settled & lock_low)); // [R11]

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         settle <= '0;
         busy_hist <= '0;
      end else begin
         settle <= next_settle;
         busy_hist <= next_busy_hist;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_isolation_test_mode <= 1'b0;
         o_queue_status_mode <= 1'b0;
      end else begin
         o_isolation_test_mode <= next_isolation;
         o_queue_status_mode <= next_queue;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_numerics_mode <= 1'b0;
      end else begin
         o_numerics_mode <= next_numerics;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_lock_strap_fault <= 1'b0;
      end else begin
         o_lock_strap_fault <= next_lock_fault;
      end
   end
endmodule

// ### logic/rms_sync.sv
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
module rms_sync #(
   parameter logic RESET_VALUE = 1'b0
) (
   input wire logic i_sys_clk, // System clock
   input wire logic i_srst, // Synchronous reset, active high
   input wire logic i_async, // Asynchronous level
   output logic o_sync // Synchronised level
);
   logic stage1;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         stage1 <= RESET_VALUE;
         o_sync <= RESET_VALUE;
      end else begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end
endmodule

// ### tb/rms_board.sv
// Board reset circuit and strap resistors
`timescale 1ns/1ns
module rms_board (
   input wire logic i_sys_clk, // Clock
   input wire logic i_hold, // Hold reset
   input wire logic [6:0] i_low, // Straps pulled low
   input wire logic [6:0] i_pullup, // Design pull-ups
   output logic o_external_reset_n, // Reset pin
   output logic [6:0] o_strap_pin // Strap levels
);
   logic flip = 1'b0;
   always @(posedge i_sys_clk) flip <= ~flip;
   assign o_external_reset_n = ~i_hold;
   // Released pins toggle so a stale level cannot pass for a strap
   assign o_strap_pin = (i_pullup & ~i_low) | (~i_pullup & {7{flip}});
endmodule

// ### tb/rms_monitor.sv
// Assertion checker for the reset and strap block
`timescale 1ns/1ns
module rms_monitor (
   input wire logic i_sys_clk, // Clock
   input wire logic i_srst, // Reset
   input wire logic i_external_reset_n, // Reset pin
   input wire logic [6:0] i_strap_pin, // Straps
   input wire logic o_core_reset, // Core reset
   input wire logic o_ctrl_inactive, // Abort drive
   input wire logic o_ctrl_float, // Abort float
   input wire logic [6:0] o_strap_oe, // Strap drive
   input wire logic [6:0] o_strap_pullup, // Pull-ups
   input wire logic o_isolation_test_mode, // Mode
   input wire logic o_queue_status_mode, // Mode
   input wire logic o_numerics_mode, // Mode
   input wire logic o_lock_strap_fault // Fault
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   wire hold = o_strap_pullup[0];
   sequence drive_s; o_ctrl_inactive [*2]; endsequence
   sequence float_s; o_ctrl_float && !o_ctrl_inactive ##1 hold; endsequence
   enter_reset_a: assert property (!i_external_reset_n [*2] |=> o_core_reset)
      else $error("core reset late");
   leave_reset_a: assert property (i_external_reset_n [*3] |=> !o_core_reset)
      else $error("core reset stuck");
   abort_order_a: assert property ($rose(o_ctrl_inactive) |-> drive_s ##1 float_s)
      else $error("abort order wrong");
   hold_pins_a: assert property (hold |-> o_strap_oe == 7'h00 && o_ctrl_float && o_core_reset)
      else $error("pins not inputs");
   run_pins_a: assert property (!o_core_reset |-> o_strap_oe == 7'h7F && !o_ctrl_float && !hold)
      else $error("pins not released");
   strap_latch_a: assert property ((hold && $stable(i_strap_pin)) [*4] ##1 !hold |->
      o_isolation_test_mode == !($past(i_strap_pin[1]) || $past(i_strap_pin[2]))
      && o_queue_status_mode == !$past(i_strap_pin[0])) else $error("strap mode wrong");
   numerics_on_a: assert property (hold && i_strap_pin[6] ##4
      (hold && !i_strap_pin[6]) [*3] ##1 !hold |-> o_numerics_mode) else $error("no numerics");
   lock_flag_a: assert property ((hold && !i_strap_pin[5]) [*3] |=> o_lock_strap_fault)
      else $error("lock not flagged");
endmodule
bind rms_reset_strap rms_monitor mon_u (.*);

// ### tb/rms_reset_strap_tb_top.sv
// Random and corner bench for the reset and strap block
`timescale 1ns/1ns
module rms_reset_strap_tb_top;
   logic clk = 1'b0, srst = 1'b1, bus = 1'b0, hold = 1'b1;
   logic [6:0] low = 7'h00;
   logic [6:0] m;
   logic n;
   wire ext_n, core, inact, flt, iso, qsm, num, lockf;
   wire [6:0] pin, oe, pu;
   int fail_count = 0, num_checks = 0;
   initial forever #5 clk = ~clk;
   rms_board board_u (.i_sys_clk(clk), .i_hold(hold), .i_low(low), .i_pullup(pu),
      .o_external_reset_n(ext_n), .o_strap_pin(pin));
   rms_reset_strap dut_u (.i_sys_clk(clk), .i_srst(srst), .i_external_reset_n(ext_n),
      .i_strap_pin(pin), .i_bus_active(bus), .o_core_reset(core), .o_ctrl_inactive(inact),
      .o_ctrl_float(flt), .o_strap_oe(oe), .o_strap_pullup(pu), .o_isolation_test_mode(iso),
      .o_queue_status_mode(qsm), .o_numerics_mode(num), .o_lock_strap_fault(lockf));
   task chk(input logic [6:0] seen, input logic [6:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic [6:0] modes(input logic [6:0] l, input logic b);
      return {4'h0, l[1] & l[2], l[0], b};
   endfunction
   initial begin
      void'($urandom(27));
      repeat (5) @(negedge clk);
      srst = 1'b0;
      repeat (8) @(negedge clk);
      hold = 1'b0;
      for (int i = 0; i < 12; i++) begin
         // Case 0 pulls every strap, lock included; random cases leave lock alone
         m = i == 0 ? 7'h7F : i == 1 ? 7'h00 : 7'($urandom) & 7'h5F;
         n = i > 1 && $urandom % 2;
         bus = i > 1 ? 1'($urandom) : 1'b1;
         repeat (10) @(negedge clk);
         hold = 1'b1;
         low = n ? m & 7'h3F : m;
         repeat (3) @(negedge clk);
         chk({5'h00, inact, flt}, {5'h00, bus, ~bus});
         repeat (9) @(negedge clk);
         chk(oe, 7'h00);
         chk(pu, 7'h7F);
         chk({5'h00, core, flt}, 7'h03);
         low[6] = n | m[6];
         repeat (6) @(negedge clk);
         hold = 1'b0;
         repeat (4) @(negedge clk);
         chk({iso, qsm, num}, modes(m, n));
         chk(oe, 7'h7F);
         chk({core, lockf}, {1'b0, m[5]});
      end
      conclude();
   end
   initial begin
      #50000;
      fail_count++;
      conclude();
   end
endmodule
